//--- verilog/pga_cfg_pkg.sv
// Package with register map, field layout, reset values and types of the input amplifier configuration block.
package pga_cfg_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // Register offsets serve directly as addresses on the plain register port.
  localparam logic [7:0] LEFT_GAIN_MUTE_ADDR  = 8'h2c;
  localparam logic [7:0] RIGHT_GAIN_MUTE_ADDR = 8'h2d;
  localparam logic [7:0] LEFT_MODE_ROUTE_ADDR  = 8'h2e;
  localparam logic [7:0] RIGHT_MODE_ROUTE_ADDR = 8'h2f;

  // Field positions.
  localparam int MUTE_BIT   = 7;
  localparam int VOL_LSB    = 0;
  localparam int VOL_W      = 5;
  localparam int CM_BIT     = 6;
  localparam int SEL_N_LSB  = 4;
  localparam int SEL_P_LSB  = 2;
  localparam int MODE_LSB   = 0;

  // Reset values.
  localparam logic       MUTE_RST  = 1'b1;
  localparam logic [4:0] VOL_RST   = 5'h05;
  localparam logic       CM_RST    = 1'b1;
  localparam logic [1:0] SEL_N_RST = 2'h0;
  localparam logic [1:0] SEL_P_RST = 2'h1;

  // Microphone mode gain: base and step in dB, saturating code.
  localparam logic [4:0] MIC_GAIN_BASE_DB = 5'h0c;
  localparam logic [4:0] MIC_GAIN_STEP_DB = 5'h03;
  localparam logic [4:0] MIC_GAIN_MAX_DB  = 5'h1e;
  localparam logic [4:0] MIC_SAT_CODE     = 5'h07;

  typedef enum logic [1:0] {
    MODE_SINGLE   = 2'b00,
    MODE_DIFF_LINE = 2'b01,
    MODE_DIFF_MIC = 2'b10,
    MODE_RESERVED = 2'b11
  } input_mode_type;

  // One-hot pin choice: bit0 pin one, bit1 pin two, bit2 pin three.
  typedef logic [2:0] pin_onehot_type;

  typedef struct packed {
    logic           silence;
    logic [4:0]     gain_code;
    logic           cm_reject_on;
    logic [1:0]     neg_pin_select;
    logic [1:0]     pos_pin_select;
    input_mode_type mode;
  } chan_cfg_type;

  typedef struct packed {
    pin_onehot_type noninv_pin;
    pin_onehot_type inv_pin;
    logic           inv_used;
    logic           path_valid;
    logic           invert_to_adc;
    logic           cm_reject_active;
    logic           silence;
    logic [4:0]     gain_code;
    logic [4:0]     mic_gain_db;
    logic           mic_gain_valid;
  } chan_ctl_type;

endpackage : pga_cfg_pkg

//--- verilog/pga_pin_decode.sv
// Pin-select decoder: two-bit field to one-hot input pin choice.
`timescale 1ns/1ps
`default_nettype none
module pga_pin_decode (
  // Select field
  input  wire logic [1:0]                 sel_i,
  // One-hot pin
  output var  pga_cfg_pkg::pin_onehot_type pin_o
);
  import pga_cfg_pkg::*;

  always_comb
  begin
    if (sel_i[1])
      pin_o = 3'h4;
    else if (sel_i[0])
      pin_o = 3'h2;
    else
      pin_o = 3'h1;
  end

endmodule : pga_pin_decode
`default_nettype wire

//--- verilog/pga_chan_decode.sv
// Per-channel decoder from stored configuration to analogue front-end controls.
`timescale 1ns/1ps
`default_nettype none
module pga_chan_decode (
  // Configuration
  input  wire pga_cfg_pkg::chan_cfg_type cfg_i,
  // Decoded controls
  output var  pga_cfg_pkg::chan_ctl_type ctl_o
);
  import pga_cfg_pkg::*;

  pin_onehot_type neg_pin;
  pin_onehot_type pos_pin;
  logic [4:0]     mic_steps;

  pga_pin_decode u_neg (
    .sel_i (cfg_i.neg_pin_select),
    .pin_o (neg_pin)
  );

  pga_pin_decode u_pos (
    .sel_i (cfg_i.pos_pin_select),
    .pin_o (pos_pin)
  );

  always_comb
  begin
    ctl_o             = '0;
    ctl_o.silence     = cfg_i.silence;
    ctl_o.gain_code   = cfg_i.gain_code;
    mic_steps         = (cfg_i.gain_code > MIC_SAT_CODE) ? MIC_SAT_CODE : cfg_i.gain_code;
    case (cfg_i.mode)
      MODE_SINGLE:
      begin
        // Only the negative select routes; the converter sees the pin inverted.
        ctl_o.inv_pin       = neg_pin;
        ctl_o.inv_used      = 1'b1;
        ctl_o.path_valid    = 1'b1;
        ctl_o.invert_to_adc = 1'b1;
      end
      MODE_DIFF_LINE:
      begin
        ctl_o.inv_pin          = neg_pin;
        ctl_o.noninv_pin       = pos_pin;
        ctl_o.inv_used         = 1'b1;
        ctl_o.path_valid       = 1'b1;
        ctl_o.cm_reject_active = cfg_i.cm_reject_on;
      end
      MODE_DIFF_MIC:
      begin
        ctl_o.inv_pin        = pos_pin;
        ctl_o.noninv_pin     = neg_pin;
        ctl_o.inv_used       = 1'b1;
        ctl_o.path_valid     = 1'b1;
        // Code zero is not a working setting; flagged invalid rather than guessed.
        ctl_o.mic_gain_valid = (cfg_i.gain_code != 5'h00);
        if (cfg_i.gain_code == 5'h00)
          ctl_o.mic_gain_db = 5'h00;
        else if (mic_steps == MIC_SAT_CODE)
          ctl_o.mic_gain_db = MIC_GAIN_MAX_DB;
        else
          ctl_o.mic_gain_db = 5'(MIC_GAIN_BASE_DB + (mic_steps - 5'h01) * MIC_GAIN_STEP_DB);
      end
      default:
      begin
        // Reserved mode leaves the path unrouted.
        ctl_o.path_valid = 1'b0;
      end
    endcase
  end

endmodule : pga_chan_decode
`default_nettype wire

//--- verilog/input_pga_config_regs.sv
// Register bank configuring the left and right analogue input amplifier paths.
//
// Overview of operation
// - Mode field bits 1:0: 00 single-ended, 01 diff line, 10 diff mic, 11 reserved.
// - Right channel settings are held and applied independently of the left.
// - Pin select 00 picks pin one, 01 pin two, 1x pin three.
// - Single-ended and line modes: negative field inverting; positive field non-inverting in line mode only.
// - Microphone mode swaps: negative field non-inverting, positive field inverting.
// - Single-ended uses negative field only; converter input is inverted.
// - Line mode: positive pin in phase, negative pin inverted.
// - Microphone gain 12 to 30 dB in 3 dB steps, saturating.
// - Mute bit 7, one mutes, muted after reset.
// - Five-bit volume in bits 4:0, reset 00101, forwarded as gain code.
// - Reset: negative select 00, positive select 01, mode 00.
// - Common-mode enable bit 6, reset one, effective only in line mode.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module input_pga_config_regs (
  // Clock and reset
  input  wire logic                             CLK_I,
  input  wire logic                             RST_I,
  // Register port
  input  wire logic [pga_cfg_pkg::ADDR_W-1:0]   ADDR_I,
  input  wire logic [pga_cfg_pkg::DATA_W-1:0]   WDATA_I,
  input  wire logic                             WR_I,
  input  wire logic                             RD_I,
  output logic      [pga_cfg_pkg::DATA_W-1:0]   RDATA_O,
  // Left front-end controls
  output var pga_cfg_pkg::chan_ctl_type         LEFT_CTL_O,
  // Right front-end controls
  output var pga_cfg_pkg::chan_ctl_type         RIGHT_CTL_O
);
  import pga_cfg_pkg::*;

  chan_cfg_type left_cfg_q;
  chan_cfg_type right_cfg_q;
  chan_ctl_type left_ctl_d;
  chan_ctl_type right_ctl_d;

  function automatic logic [DATA_W-1:0] gain_word(input chan_cfg_type c);
    logic [DATA_W-1:0] w;
    w                            = '0;
    w[MUTE_BIT]                  = c.silence;
    w[VOL_LSB +: VOL_W]          = c.gain_code;
    return w;
  endfunction : gain_word

  function automatic logic [DATA_W-1:0] route_word(input chan_cfg_type c);
    logic [DATA_W-1:0] w;
    w                   = '0;
    w[CM_BIT]           = c.cm_reject_on;
    w[SEL_N_LSB +: 2]   = c.neg_pin_select;
    w[SEL_P_LSB +: 2]   = c.pos_pin_select;
    w[MODE_LSB +: 2]    = c.mode;
    return w;
  endfunction : route_word

  // Left gain and mute register.
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      left_cfg_q.silence   <= MUTE_RST;
      left_cfg_q.gain_code <= VOL_RST;
    end
    else if (WR_I && ADDR_I == LEFT_GAIN_MUTE_ADDR)
    begin
      left_cfg_q.silence   <= WDATA_I[MUTE_BIT];
      left_cfg_q.gain_code <= WDATA_I[VOL_LSB +: VOL_W];
    end
  end

  // Left mode and routing register.
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      left_cfg_q.cm_reject_on   <= CM_RST;
      left_cfg_q.neg_pin_select <= SEL_N_RST;
      left_cfg_q.pos_pin_select <= SEL_P_RST;
      left_cfg_q.mode           <= MODE_SINGLE;
    end
    else if (WR_I && ADDR_I == LEFT_MODE_ROUTE_ADDR)
    begin
      left_cfg_q.cm_reject_on   <= WDATA_I[CM_BIT];
      left_cfg_q.neg_pin_select <= WDATA_I[SEL_N_LSB +: 2];
      left_cfg_q.pos_pin_select <= WDATA_I[SEL_P_LSB +: 2];
      left_cfg_q.mode           <= input_mode_type'(WDATA_I[MODE_LSB +: 2]);
    end
  end

  // Right channel registers have their own storage and decode.
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      right_cfg_q.silence   <= MUTE_RST;
      right_cfg_q.gain_code <= VOL_RST;
    end
    else if (WR_I && ADDR_I == RIGHT_GAIN_MUTE_ADDR)
    begin
      right_cfg_q.silence   <= WDATA_I[MUTE_BIT];
      right_cfg_q.gain_code <= WDATA_I[VOL_LSB +: VOL_W];
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      right_cfg_q.cm_reject_on   <= CM_RST;
      right_cfg_q.neg_pin_select <= SEL_N_RST;
      right_cfg_q.pos_pin_select <= SEL_P_RST;
      right_cfg_q.mode           <= MODE_SINGLE;
    end
    else if (WR_I && ADDR_I == RIGHT_MODE_ROUTE_ADDR)
    begin
      right_cfg_q.cm_reject_on   <= WDATA_I[CM_BIT];
      right_cfg_q.neg_pin_select <= WDATA_I[SEL_N_LSB +: 2];
      right_cfg_q.pos_pin_select <= WDATA_I[SEL_P_LSB +: 2];
      right_cfg_q.mode           <= input_mode_type'(WDATA_I[MODE_LSB +: 2]);
    end
  end

  pga_chan_decode u_left (
    .cfg_i (left_cfg_q),
    .ctl_o (left_ctl_d)
  );

  pga_chan_decode u_right (
    .cfg_i (right_cfg_q),
    .ctl_o (right_ctl_d)
  );

  // Outputs are registered from the stored fields, so a write shows one edge after the edge that takes it.
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      LEFT_CTL_O  <= '0;
      RIGHT_CTL_O <= '0;
    end
    else
    begin
      LEFT_CTL_O  <= left_ctl_d;
      RIGHT_CTL_O <= right_ctl_d;
    end
  end

  // Read data stands only in the cycle after the strobe; unmapped reads return zero.
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      RDATA_O <= '0;
    else if (RD_I)
    begin
      case (ADDR_I)
        LEFT_GAIN_MUTE_ADDR:   RDATA_O <= gain_word(left_cfg_q);
        RIGHT_GAIN_MUTE_ADDR:  RDATA_O <= gain_word(right_cfg_q);
        LEFT_MODE_ROUTE_ADDR:  RDATA_O <= route_word(left_cfg_q);
        RIGHT_MODE_ROUTE_ADDR: RDATA_O <= route_word(right_cfg_q);
        default:               RDATA_O <= '0;
      endcase
    end
    else
      RDATA_O <= '0;
  end

endmodule : input_pga_config_regs
`default_nettype wire

//--- sim/input_pga_config_regs_asserts.sv
// Checker on the ports of the input amplifier register bank.
`timescale 1ns/1ps
`default_nettype none
module pga_cfg_checker (
  // Clock and reset
  input wire logic                              CLK_I,
  input wire logic                              RST_I,
  // Register port
  input wire logic [pga_cfg_pkg::ADDR_W-1:0]    ADDR_I,
  input wire logic [pga_cfg_pkg::DATA_W-1:0]    WDATA_I,
  input wire logic                              WR_I,
  input wire logic                              RD_I,
  input wire logic [pga_cfg_pkg::DATA_W-1:0]    RDATA_O,
  // Front-end controls
  input wire pga_cfg_pkg::chan_ctl_type         LEFT_CTL_O,
  input wire pga_cfg_pkg::chan_ctl_type         RIGHT_CTL_O
);
  import pga_cfg_pkg::*;
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);
  a_se_inverts: assert property (LEFT_CTL_O.invert_to_adc |-> LEFT_CTL_O.path_valid && !LEFT_CTL_O.noninv_pin)
    else $error("single-ended path misrouted");
  a_pins_onehot: assert property ($onehot0(LEFT_CTL_O.inv_pin) && $onehot0(RIGHT_CTL_O.noninv_pin))
    else $error("pin choice not one-hot");
  a_cm_line_only: assert property (RIGHT_CTL_O.cm_reject_active |-> RIGHT_CTL_O.path_valid &&
    !RIGHT_CTL_O.invert_to_adc && !RIGHT_CTL_O.mic_gain_valid) else $error("cm reject outside line mode");
  a_mic_gain_map: assert property (LEFT_CTL_O.mic_gain_valid |-> LEFT_CTL_O.mic_gain_db ==
    (LEFT_CTL_O.gain_code > 5'h06 ? 5'h1e : 5'h09 + 5'h03 * LEFT_CTL_O.gain_code)) else $error("mic gain wrong");
  a_reserved_unrouted: assert property (!RIGHT_CTL_O.path_valid |-> !RIGHT_CTL_O.inv_pin &&
    !RIGHT_CTL_O.noninv_pin && !RIGHT_CTL_O.invert_to_adc) else $error("reserved mode routed");
  a_line_lag: assert property (WR_I && ADDR_I == 8'h2e && WDATA_I[1:0] == 2'h1 |-> ##2
    !LEFT_CTL_O.invert_to_adc && LEFT_CTL_O.cm_reject_active == $past(WDATA_I[6], 2)) else $error("line mode lag");
  a_mute_lag: assert property (WR_I && ADDR_I == 8'h2d |-> ##2 RIGHT_CTL_O.silence == $past(WDATA_I[7], 2) &&
    RIGHT_CTL_O.gain_code == $past(WDATA_I[4:0], 2)) else $error("right gain lag");
  a_left_holds: assert property (WR_I && ADDR_I[0] |-> ##2 $stable(LEFT_CTL_O))
    else $error("left changed by right write");
  a_gain_readback: assert property (RD_I && ADDR_I == 8'h2c |=> RDATA_O[7] == LEFT_CTL_O.silence &&
    RDATA_O[4:0] == LEFT_CTL_O.gain_code) else $error("left gain readback differs from output");
endmodule : pga_cfg_checker
bind input_pga_config_regs pga_cfg_checker i_chk (.CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .LEFT_CTL_O(LEFT_CTL_O),
  .RIGHT_CTL_O(RIGHT_CTL_O));
`default_nettype wire

//--- sim/input_pga_config_regs_test.sv
// Self-checking bench for the input amplifier register bank.
`timescale 1ns/1ps
`default_nettype none
module input_pga_config_regs_test;
  import pga_cfg_pkg::*;
  logic         clk = 1'b0;
  logic         rst;
  logic [7:0]   addr;
  logic [15:0]  wdata;
  logic         wr;
  logic         rd;
  logic [15:0]  rdata;
  chan_ctl_type lctl;
  chan_ctl_type rctl;
  logic [15:0]  sh [4];
  logic [63:0]  rq [$];
  logic [63:0]  cq [$];
  logic         rt = 1'b0;
  logic         w1 = 1'b0;
  logic         w2 = 1'b0;
  int           cyc = 0;
  int           mismatches = 0;
  int           compares = 0;

  input_pga_config_regs i_dut (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .LEFT_CTL_O(lctl), .RIGHT_CTL_O(rctl));

  initial
  begin
    forever #5 clk = ~clk;
  end

  function automatic pin_onehot_type oh(logic [1:0] s);
    return s[1] ? 3'h4 : (s[0] ? 3'h2 : 3'h1);
  endfunction : oh

  function automatic chan_ctl_type dec(logic [15:0] g, logic [15:0] r);
    chan_ctl_type c;
    logic [1:0]   m;
    m = r[1:0];
    c = '0;
    c.silence = g[7];
    c.gain_code = g[4:0];
    c.path_valid = m != 2'h3;
    c.inv_used = c.path_valid;
    c.invert_to_adc = m == 2'h0;
    c.cm_reject_active = r[6] && m == 2'h1;
    c.inv_pin = m == 2'h2 ? oh(r[3:2]) : (m == 2'h3 ? 3'h0 : oh(r[5:4]));
    c.noninv_pin = m == 2'h2 ? oh(r[5:4]) : (m == 2'h1 ? oh(r[3:2]) : 3'h0);
    c.mic_gain_valid = m == 2'h2 && g[4:0] != 5'h00;
    if (c.mic_gain_valid)
      c.mic_gain_db = g[4:0] > 5'h06 ? 5'h1e : 5'h09 + 5'h03 * g[4:0];
    return c;
  endfunction : dec

  task automatic chk(logic [63:0] s, logic [63:0] e);
    compares++;
    if (s !== e)
    begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic close_out;
    if (mismatches == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  task automatic wr_reg(logic [7:0] a, logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
    if (a inside {[8'h2c:8'h2f]})
      sh[a[1:0]] = d & (a[1] ? 16'h007f : 16'h009f);
    cq.push_back({dec(sh[0], sh[2]), dec(sh[1], sh[3])});
    @(posedge clk);
  endtask : wr_reg

  task automatic rd_reg(logic [7:0] a);
    addr <= a;
    wr <= 1'b0;
    rd <= 1'b1;
    rq.push_back((a inside {[8'h2c:8'h2f]}) ? sh[a[1:0]] : 16'h0000);
    @(posedge clk);
  endtask : rd_reg

  task automatic idle(int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : idle

  // Volume is only changed while muted, so the path never sees a gain step live.
  task automatic set_gain(logic ch, logic [4:0] v, logic m);
    wr_reg(8'h2c + ch, {8'h00, 1'h1, 2'h0, sh[ch][4:0]});
    wr_reg(8'h2c + ch, {8'h00, 1'h1, 2'h0, v});
    wr_reg(8'h2c + ch, {8'h00, m, 2'h0, v});
    rd_reg(8'h2c + ch);
  endtask : set_gain

  task automatic rst_seq;
    rst <= 1'b1;
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    sh = '{16'h0085, 16'h0085, 16'h0044, 16'h0044};
    @(posedge clk);
    @(negedge clk);
    chk({lctl, rctl}, {dec(sh[0], sh[2]), dec(sh[1], sh[3])});
    @(posedge clk);
    wr_reg(8'h2b, 16'hffff);
    wr_reg(8'h30, 16'hffff);
    for (int a = 8'h2b; a <= 8'h30; a++)
      rd_reg(8'(a));
    idle(3);
  endtask : rst_seq

  always @(posedge clk)
  begin
    rt <= rd & ~rst;
    w1 <= wr & ~rst;
    w2 <= w1;
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      mismatches++;
      close_out();
    end
  end

  always @(negedge clk)
  begin
    if (rt)
      chk(rdata, rq.pop_front());
    if (w2)
      chk({lctl, rctl}, cq.pop_front());
  end

  initial
  begin
    logic [15:0] d;
    logic [7:0]  a;
    addr = 8'h00;
    wdata = 16'h0000;
    void'($urandom(40375));
    rst_seq();
    for (int i = 0; i < 64; i++)
    begin
      d = 16'($urandom());
      d[5:0] = 6'(i);
      wr_reg(8'h2e, d);
      wr_reg(8'h2f, 16'($urandom()));
      rd_reg(8'h2e);
      rd_reg(8'h2f);
    end
    wr_reg(8'h2e, 16'h0042);
    wr_reg(8'h2f, 16'h0026);
    for (int v = 1; v < 32; v++)
    begin
      set_gain(1'b0, 5'(v), 1'(v));
      set_gain(1'b1, 5'(32 - v), 1'(v >> 1));
    end
    repeat (150)
    begin
      a = 8'h2c + 8'($urandom_range(3));
      if (a[1])
        wr_reg(a, 16'($urandom()));
      else
        set_gain(a[0], 5'($urandom_range(31, 1)), 1'($urandom()));
      rd_reg(a);
    end
    idle(4);
    rst_seq();
    close_out();
  end
endmodule : input_pga_config_regs_test
`default_nettype wire
